/* common/lcdslp_map.svh */
`ifndef LCDSLP_MAP_SVH
`define LCDSLP_MAP_SVH
// Register byte offsets
`define LCDSLP_CTRL_OFS 8'h00
`define LCDSLP_STAT_OFS 8'h04
`define LCDSLP_PIX_OFS  8'h10
// Control register fields and reset value
`define LCDSLP_CTRL_RST 8'h00
`define LCDSLP_BIT_EN    7
`define LCDSLP_BIT_SLEEP_EN 6
`define LCDSLP_BIT_BIAS_SEL 4
`define LCDSLP_CS_MSB    1
`define LCDSLP_CS_LSB    0
// Display clock sources
`define LCDSLP_CS_SYS 2'h0
`define LCDSLP_CS_T1  2'h1
// Timing
`define LCDSLP_CLK_NS  100
`define LCDSLP_STEP_NS 2000000
`endif

/* common/lcdslp_pkg.sv */
`default_nettype none
package lcdslp_pkg;
  typedef enum logic [1:0] {
    LCDSLP_OFF,
    LCDSLP_RUN,
    LCDSLP_HALT
  } lcdslp_state_e;
endpackage
`default_nettype wire

/* common/lcdslp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lcdslp_if #(
  parameter int COMS = 4,
  parameter int SEGS = 32,
  parameter int IW   = 2
);
  logic                       tick;
  logic                       run;
  logic                       restart;
  logic [COMS-1:0][SEGS-1:0]  pix;
  logic [SEGS-1:0]            seg;
  logic [COMS-1:0]            com;
  logic [IW-1:0]              idx;
  logic                       frame_pulse;
  modport ctl (output tick, run, restart, pix,
               input  seg, com, idx, frame_pulse);
  modport frm (input  tick, run, restart, pix,
               output seg, com, idx, frame_pulse);
endinterface
`default_nettype wire

/* hdl/lcdslp_frame.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdslp_frame #(
  parameter int COMS = 4,
  parameter int SEGS = 32,
  parameter int IW   = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  lcdslp_if.frm    lnk
);
  logic [IW-1:0]   idx_r;
  logic [IW-1:0]   idx_nxt;
  logic [COMS-1:0] com_r;
  logic [SEGS-1:0] seg_r;
  logic            fp_r;

  assign idx_nxt = (idx_r == IW'(COMS-1)) ? '0 : IW'(idx_r + 1'b1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_r <= '0;
      com_r <= '0;
      seg_r <= '0;
    end
    else if (lnk.restart)
    begin
      idx_r <= '0;
      com_r <= COMS'(1);
      seg_r <= lnk.pix[0];
    end
    else if (lnk.run && lnk.tick)
    begin
      idx_r <= idx_nxt;
      com_r <= COMS'(1) << idx_nxt;
      seg_r <= lnk.pix[idx_nxt];
    end
  end

  // Frame ends after last common step
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fp_r <= 1'b0;
    else
      fp_r <= lnk.run && lnk.tick && !lnk.restart &&
              (idx_r == IW'(COMS-1));
  end

  assign lnk.idx         = idx_r;
  assign lnk.com         = com_r;
  assign lnk.seg         = seg_r;
  assign lnk.frame_pulse = fp_r;
endmodule // lcdslp_frame
`default_nettype wire

/* hdl/lcdslp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdslp_map.svh"
module lcdslp_top #(
  parameter int COMS     = 4,
  parameter int SEGS     = 32,
  parameter int STEP_CYC = `LCDSLP_STEP_NS / `LCDSLP_CLK_NS
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  input  wire logic            core_sleep,
  input  wire logic            timer_osc_tick,
  input  wire logic            rc_osc_tick,
  output logic [SEGS-1:0]      lcd_seg,
  output logic [COMS-1:0]      lcd_com,
  output logic                 frame_boundary,
  output logic                 charge_pump_on,
  output logic                 top_bias_to_supply
);
  localparam int IW = (COMS > 1) ? $clog2(COMS) : 1;
  localparam int DW = $clog2(STEP_CYC + 1);

  logic [7:0]                 ctrl_r;
  logic [COMS-1:0][SEGS-1:0]  pix_r;
  lcdslp_pkg::lcdslp_state_e  state_r;
  lcdslp_pkg::lcdslp_state_e  state_nxt;
  logic [31:0]                hrdata_r;
  logic                       wr_pend_r;
  logic [7:0]                 wr_addr_r;
  logic [DW-1:0]              div_r;
  logic                       sys_tick;
  logic                       addr_ok;
  logic [1:0]                 clk_sel;
  logic                       halt_cond;
  logic                       run;
  logic                       tick;
  logic [31:0]                stat_word;

  lcdslp_if #(.COMS(COMS), .SEGS(SEGS), .IW(IW)) lnk ();

  lcdslp_frame #(.COMS(COMS), .SEGS(SEGS), .IW(IW)) u_frame (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lnk     (lnk.frm)
  );

  function automatic logic pix_hit(input logic [7:0] a);
    pix_hit = (a >= `LCDSLP_PIX_OFS) &&
              (a < `LCDSLP_PIX_OFS + 8'(4 * COMS)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [IW-1:0] pix_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LCDSLP_PIX_OFS;
    pix_idx = d[IW+1:2];
  endfunction

  // Zero-wait slave, only whole-word transfers are taken
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign addr_ok   = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= `LCDSLP_CTRL_RST;
    else if (wr_pend_r && wr_addr_r == `LCDSLP_CTRL_OFS)
      ctrl_r <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pix_r <= '0;
    else if (wr_pend_r && !core_sleep && pix_hit(wr_addr_r))
      pix_r[pix_idx(wr_addr_r)] <= hwdata[SEGS-1:0];
  end

  assign stat_word = 32'({lnk.idx, 4'h0, core_sleep, charge_pump_on,
                          2'(state_r)});

  // Read data sampled in address phase, so a read right after a
  // write to the same word still returns the old value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0;
    else if (addr_ok && !hwrite)
    begin
      if (haddr[7:0] == `LCDSLP_CTRL_OFS)
        hrdata_r <= 32'(ctrl_r);
      else if (haddr[7:0] == `LCDSLP_STAT_OFS)
        hrdata_r <= stat_word;
      else if (pix_hit(haddr[7:0]))
        hrdata_r <= 32'(pix_r[pix_idx(haddr[7:0])]);
      else
        hrdata_r <= 32'h0;
    end
  end

  // System clock divider for select 00
  assign sys_tick = (div_r == DW'(STEP_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_r <= '0;
    else if (sys_tick)
      div_r <= '0;
    else
      div_r <= DW'(div_r + 1'b1);
  end

  assign clk_sel = ctrl_r[`LCDSLP_CS_MSB:`LCDSLP_CS_LSB];

  always_comb
  begin
    case (clk_sel)
      `LCDSLP_CS_SYS: tick = sys_tick;
      `LCDSLP_CS_T1:  tick = timer_osc_tick;
      default:        tick = rc_osc_tick;
    endcase
  end

  assign halt_cond = ctrl_r[`LCDSLP_BIT_SLEEP_EN] ||
                     (clk_sel == `LCDSLP_CS_SYS);
  assign run = ctrl_r[`LCDSLP_BIT_EN] && !(core_sleep && halt_cond);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      lcdslp_pkg::LCDSLP_OFF:
        if (run)
          state_nxt = lcdslp_pkg::LCDSLP_RUN;
        // Enabled but stopped by sleep counts as halted
        else if (ctrl_r[`LCDSLP_BIT_EN])
          state_nxt = lcdslp_pkg::LCDSLP_HALT;
      lcdslp_pkg::LCDSLP_RUN:
        if (!ctrl_r[`LCDSLP_BIT_EN])
          state_nxt = lcdslp_pkg::LCDSLP_OFF;
        else if (!run)
          state_nxt = lcdslp_pkg::LCDSLP_HALT;
      lcdslp_pkg::LCDSLP_HALT:
        if (!ctrl_r[`LCDSLP_BIT_EN])
          state_nxt = lcdslp_pkg::LCDSLP_OFF;
        else if (run)
          state_nxt = lcdslp_pkg::LCDSLP_RUN;
      default:
        state_nxt = lcdslp_pkg::LCDSLP_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= lcdslp_pkg::LCDSLP_OFF;
    else
      state_r <= state_nxt;
  end

  assign lnk.tick    = tick;
  assign lnk.run     = run;
  assign lnk.pix     = pix_r;
  assign lnk.restart = run && (state_r != lcdslp_pkg::LCDSLP_RUN);

  assign lcd_seg = run ? lnk.seg : '0;
  assign lcd_com = run ? lnk.com : '0;
  // Boundary marker lets software time its sleep request
  assign frame_boundary = lnk.frame_pulse;

  assign charge_pump_on     = run && ctrl_r[`LCDSLP_BIT_BIAS_SEL];
  assign top_bias_to_supply = !charge_pump_on;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_sleep_en_store: assert property (
    (wr_pend_r && wr_addr_r == `LCDSLP_CTRL_OFS) |=>
      ctrl_r[`LCDSLP_BIT_SLEEP_EN] ==
        $past(hwdata[`LCDSLP_BIT_SLEEP_EN]))
    else $error("sleep enable bit not stored");
  chk_halt_blank: assert property (
    (core_sleep && ctrl_r[`LCDSLP_BIT_SLEEP_EN]) |->
      (lcd_seg == '0 && lcd_com == '0 && !charge_pump_on))
    else $error("lines driven while halted");
  chk_sleep_run: assert property (
    (core_sleep && ctrl_r[`LCDSLP_BIT_EN] &&
     !ctrl_r[`LCDSLP_BIT_SLEEP_EN] && clk_sel != `LCDSLP_CS_SYS) |->
      run)
    else $error("display stopped in sleep");
  chk_step_adv: assert property (
    (run && tick && !lnk.restart && COMS > 1) |=>
      lnk.idx != $past(lnk.idx))
    else $error("common step did not advance");
  chk_pix_frozen: assert property (
    core_sleep |=> $stable(pix_r))
    else $error("pixel data changed in sleep");
  chk_sleep_clk: assert property (
    (run && core_sleep) |-> clk_sel != `LCDSLP_CS_SYS)
    else $error("ran in sleep on system clock");
  chk_cs_halt: assert property (
    (core_sleep && clk_sel == `LCDSLP_CS_SYS && ctrl_r[`LCDSLP_BIT_EN]
     ##1 core_sleep) |->
      state_r == lcdslp_pkg::LCDSLP_HALT && lcd_com == '0)
    else $error("no halt with system clock");
  chk_pump_sel: assert property (
    run |-> charge_pump_on == ctrl_r[`LCDSLP_BIT_BIAS_SEL])
    else $error("pump does not follow select");
  chk_top_tie: assert property (
    (!run || !ctrl_r[`LCDSLP_BIT_BIAS_SEL]) |-> top_bias_to_supply)
    else $error("top bias not tied to supply");
  chk_wake_resume: assert property (
    (state_r == lcdslp_pkg::LCDSLP_HALT && run) |=>
      (state_r == lcdslp_pkg::LCDSLP_RUN && lnk.idx == '0 &&
       lnk.com == COMS'(1)))
    else $error("no resume after wake");

  cov_halt: cover property (
    state_r == lcdslp_pkg::LCDSLP_RUN ##1
    state_r == lcdslp_pkg::LCDSLP_HALT);
  cov_sleep_run: cover property (core_sleep && run && tick);
  cov_sleep_frame: cover property (core_sleep && frame_boundary);
  cov_wake: cover property (
    state_r == lcdslp_pkg::LCDSLP_HALT ##1
    state_r == lcdslp_pkg::LCDSLP_RUN);
endmodule // lcdslp_top
`default_nettype wire

/* tb/lcdslp_glass.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdslp_glass #(
  parameter int COMS = 4,
  parameter int SEGS = 32
) (
  input  wire logic [SEGS-1:0] lcd_seg,
  input  wire logic [COMS-1:0] lcd_com,
  output logic                 blank
);
  // Glass sees drive levels only; all zero is minimum voltage
  assign blank = (lcd_com == '0) && (lcd_seg == '0);
endmodule // lcdslp_glass
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdslp_map.svh"
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        core_sleep;
  logic        timer_osc_tick;
  logic        rc_osc_tick;
  logic [31:0] lcd_seg;
  logic [3:0]  lcd_com;
  logic        frame_boundary;
  logic        charge_pump_on;
  logic        top_bias_to_supply;
  logic        blank;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  localparam int STEP = 8;

  assign hready = hreadyout;

  lcdslp_top #(.STEP_CYC(STEP)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .core_sleep(core_sleep),
    .timer_osc_tick(timer_osc_tick), .rc_osc_tick(rc_osc_tick),
    .lcd_seg(lcd_seg), .lcd_com(lcd_com),
    .frame_boundary(frame_boundary), .charge_pump_on(charge_pump_on),
    .top_bias_to_supply(top_bias_to_supply)
  );

  lcdslp_glass glass (.lcd_seg(lcd_seg), .lcd_com(lcd_com), .blank(blank));

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  function automatic logic [31:0] pix(input int i);
    return 32'(32'h11111111 * (i + 1));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // One step per tick; timer source when tmr is high
  task automatic tick(input logic tmr, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      rc_osc_tick    <= !tmr;
      timer_osc_tick <= tmr;
      @(posedge hclk);
      rc_osc_tick    <= 1'b0;
      timer_osc_tick <= 1'b0;
    end
    #1;
  endtask

  task automatic t_reset;
    chk(hreadyout, 1'b1);
    chk(hresp, 1'b0);
    chk(blank, 1'b1);
    chk(top_bias_to_supply, 1'b1);
    rd(`LCDSLP_CTRL_OFS, 32'h0);
    rd(8'h08, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_run;
    for (int i = 0; i < 4; i++) wr(8'(8'h10 + 4 * i), pix(i));
    wr(`LCDSLP_CTRL_OFS, 32'h93);
    @(posedge hclk);
    #1;
    chk(lcd_com, 4'h1);
    chk(lcd_seg, pix(0));
    chk(charge_pump_on, 1'b1);
    chk(top_bias_to_supply, 1'b0);
    tick(1'b0, 1);
    chk(lcd_com, 4'h2);
    chk(lcd_seg, pix(1));
    $display("test run done");
  endtask

  task automatic t_awake;
    wr(`LCDSLP_CTRL_OFS, 32'h81);
    core_sleep <= 1'b1;
    wr(8'h10, 32'hFFFF0000);
    tick(1'b1, 1);
    chk(lcd_com, 4'h4);
    chk(lcd_seg, pix(2));
    rd(8'h10, pix(0));
    core_sleep <= 1'b0;
    $display("test awake sleep done");
  endtask

  task automatic t_halt;
    int n;
    n = 0;
    wr(`LCDSLP_CTRL_OFS, 32'hD3);
    tick(1'b0, 2);
    while (frame_boundary !== 1'b1 && n < 3)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(frame_boundary, 1'b1);
    // Sleep right after the frame boundary
    core_sleep <= 1'b1;
    #1;
    chk(blank, 1'b1);
    chk(top_bias_to_supply, 1'b1);
    tick(1'b0, 1);
    chk(blank, 1'b1);
    rd(`LCDSLP_CTRL_OFS, 32'hD3);
    core_sleep <= 1'b0;
    @(posedge hclk);
    #1;
    chk(lcd_com, 4'h1);
    chk(lcd_seg, pix(0));
    $display("test halt done");
  endtask

  // Divider gives exactly one step in any STEP edges
  task automatic t_sysclk;
    logic [3:0]  c;
    logic [31:0] q;
    wr(`LCDSLP_CTRL_OFS, 32'h80);
    @(posedge hclk);
    #1;
    c = lcd_com;
    repeat (STEP) @(posedge hclk);
    #1;
    chk(lcd_com, {c[2:0], c[3]});
    core_sleep <= 1'b1;
    #1;
    chk(blank, 1'b1);
    repeat (2) @(posedge hclk);
    #1;
    chk(blank, 1'b1);
    // Status low byte: halted, core asleep, pump off
    bus(1'b0, `LCDSLP_STAT_OFS, 32'h0, q);
    chk(q & 32'h000000FF, 32'h0000000A);
    core_sleep <= 1'b0;
    @(posedge hclk);
    #1;
    chk(lcd_com, 4'h1);
    chk(lcd_seg, pix(0));
    $display("test system clock sleep done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs well under a hundred cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_sleep = 1'b0;
    timer_osc_tick = 1'b0;
    rc_osc_tick = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    t_reset();
    t_run();
    t_awake();
    t_halt();
    t_sysclk();
    results();
  end
endmodule // tb_top
`default_nettype wire
